// [tb.sv]
/*
 Self-checking testbench for the prescaled watchdog with a register model.
 Assumes the constants header and the checker file are compiled alongside.
*/
`timescale 1ns/10ps
`include "watchdog_consts.svh"
module tb;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [13:0] addr = 14'h0000;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  cfg = 8'h00;
   logic [3:0]  pls = 4'h0;
   logic        xtal = 1'b0;
   logic [7:0]  rdata;
   logic [7:0]  r;
   logic [1:0]  csel;
   logic        wdr, wake, tflag, busy, irq;
   int          n_errors = 0;
   int          samples_checked = 0;
   int          ctrl_m = 8;
   int          c;

   // The start-up count is far too long to finish here, so only its hold is checked.
   watchdog_timer_prescaled i_watchdog_timer_prescaled (.core_clk_i(clk), .rst_b_i(rst_b),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .configuration_word_i(cfg),
      .clear_watchdog_cmd_i(pls[0]), .sleep_cmd_i(pls[1]), .crystal_clock_i(xtal),
      .ost_start_i(pls[3]), .clock_fail_i(pls[2]), .rdata_o(rdata), .watchdog_reset_o(wdr),
      .wake_o(wake), .timeout_flag_o(tflag), .system_clock_select_o(csel),
      .ost_busy_o(busy), .irq_o(irq));

   // ======================================================================
   // Tasks
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task results;
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results

   task wr_reg(input logic [13:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      if (a == `OFS_WATCHDOG_CONTROL)
         ctrl_m = d & 8'h1F;
   endtask : wr_reg

   task rd_reg(input logic [13:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      r = rdata;
   endtask : rd_reg

   task pulse(input int b);
      @(posedge clk);
      pls[b] <= 1'b1;
      @(posedge clk);
      pls <= 4'h0;
      #1;
   endtask : pulse

   // A wait that must see its pulse and runs out ends the run with a mismatch.
   task wait_ev(input logic sel, input int lim, input logic must);
      c = 0;
      do
      begin
         @(posedge clk);
         #1;
         c++;
      end
      while ((sel ? wake : wdr) !== 1'b1 && c < lim);
      if (must && (sel ? wake : wdr) !== 1'b1)
      begin
         n_errors++;
         $display("MISMATCH at %0t: awaited pulse missing", $time);
         results;
      end
   endtask : wait_ev

   task settle;
      repeat (2) @(posedge clk);
      #1;
   endtask : settle

   // ======================================================================
   // Stimulus
   initial
   begin
      forever #2.5 clk = ~clk;
   end

   initial
   begin
      c = $urandom(58);
      cfg <= 8'($urandom) & 8'hFB;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      rd_reg(`OFS_WATCHDOG_CONTROL);
      check(r, ctrl_m);
      rd_reg(`OFS_OPTION_CONTROL);
      check(r, `RST_OPTION_CONTROL);
      rd_reg(14'h0200);
      check(r, 8'h00);
      wr_reg(`OFS_CONFIG_WORD, 8'hFF);
      rd_reg(`OFS_CONFIG_WORD);
      check(r, cfg);
      repeat (4)
      begin
         wr_reg(`OFS_WATCHDOG_CONTROL, 8'($urandom));
         rd_reg(`OFS_WATCHDOG_CONTROL);
         check(r, ctrl_m);
      end
      wr_reg(`OFS_OPTION_CONTROL, 8'hF7);
      rd_reg(`OFS_OPTION_ALIAS);
      check(r, 8'hF7);
      wr_reg(`OFS_WATCHDOG_CONTROL, 8'h18);
      wait_ev(1'b0, 13000, 1'b0);
      check(wdr, 1'b0);
      @(posedge clk);
      cfg <= cfg | 8'h04;
      wait_ev(1'b0, 7000, 1'b1);
      wait_ev(1'b0, 7000, 1'b1);
      check(c, `INTERNAL_RC_OSC_DIV);
      check(tflag, 1'b0);
      settle;
      check(irq, 1'b0);
      wr_reg(`OFS_IRQ_MASK, 8'h01);
      settle;
      check(irq, 1'b1);
      rd_reg(`OFS_IRQ_STATUS);
      check(r, 8'h01);
      settle;
      check(irq, 1'b0);
      pulse(0);
      check(tflag, 1'b1);
      pulse(2);
      check(csel, 2'h2);
      pulse(1);
      check(tflag, 1'b1);
      check(csel, 2'h0);
      wait_ev(1'b1, 7000, 1'b1);
      settle;
      check(tflag, 1'b0);
      wr_reg(`OFS_OPTION_CONTROL, 8'hF9);
      wait_ev(1'b0, 14000, 1'b1);
      wait_ev(1'b0, 14000, 1'b1);
      check(c, 2 * `INTERNAL_RC_OSC_DIV);
      pulse(3);
      settle;
      check(busy, 1'b1);
      wait_ev(1'b0, 13000, 1'b0);
      check(wdr, 1'b0);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      ctrl_m = 8;
      rd_reg(`OFS_WATCHDOG_CONTROL);
      check(r, ctrl_m);
      check(busy, 1'b0);
      wr_reg(`OFS_OPTION_CONTROL, 8'hF7);
      wr_reg(`OFS_WATCHDOG_CONTROL, 8'h18);
      xtal <= 1'b1;
      pulse(1);
      wait_ev(1'b1, 7000, 1'b1);
      settle;
      check(busy, 1'b1);
      wait_ev(1'b0, 7000, 1'b0);
      check(wdr, 1'b0);
      results;
   end
endmodule : tb

bind watchdog_timer_prescaled watchdog_timer_prescaled_checker i_watchdog_timer_prescaled_checker (
   .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .configuration_word_i(configuration_word_i),
   .clear_watchdog_cmd_i(clear_watchdog_cmd_i), .sleep_cmd_i(sleep_cmd_i),
   .crystal_clock_i(crystal_clock_i), .ost_start_i(ost_start_i), .clock_fail_i(clock_fail_i),
   .rdata_o(rdata_o), .watchdog_reset_o(watchdog_reset_o), .wake_o(wake_o),
   .timeout_flag_o(timeout_flag_o), .system_clock_select_o(system_clock_select_o),
   .ost_busy_o(ost_busy_o), .irq_o(irq_o));

// [watchdog_consts.svh]
/*
 Constants for the prescaled watchdog: register offsets, field positions,
 reset values and timing counts. Assumes inclusion by its bare name.
*/
`ifndef WATCHDOG_CONSTS_SVH
`define WATCHDOG_CONSTS_SVH

// ==========================================================================
// Register offsets
`define OFS_OPTION_CONTROL    14'h0081
`define OFS_OPTION_ALIAS      14'h0181
`define OFS_WATCHDOG_CONTROL  14'h0105
`define OFS_CONFIG_WORD       14'h2007
`define OFS_IRQ_STATUS        14'h0110
`define OFS_IRQ_MASK          14'h0111
`define OFS_WD_STATUS         14'h0112

// ==========================================================================
// Reset values and fields
`define RST_OPTION_CONTROL    8'hFF
`define RST_WATCHDOG_CONTROL  8'h08
`define BIT_SW_ENABLE         0
`define BIT_PRESCALER_ASSIGN  3
`define CFG_FORCE_ON_BIT      2
`define PERIOD_SEL_ONE        4'hC

// ==========================================================================
// Timing
`define CORE_CLK_KHZ          200000
`define INTERNAL_RC_OSC_KHZ_X100        3125
`define INTERNAL_RC_OSC_DIV             ((`CORE_CLK_KHZ * 100) / `INTERNAL_RC_OSC_KHZ_X100)
`define OST_CYCLES            1024
`define BASE_PERIOD_US        16380

`endif

// [watchdog_pkg.sv]
/*
 Types for the prescaled watchdog. Assumes the constants header alongside.
*/
package watchdog_pkg;
   typedef enum logic [1:0] {ST_RUN, ST_OST, ST_SLEEP} wd_state_t;
endpackage : watchdog_pkg

// [watchdog_timer_prescaled.sv]
/*
 Prescaled watchdog timer with register port, sleep and start-up handling.
 Assumes one 200 MHz clock, synchronous pin inputs and a plain register
 master that never issues read and write strobes together.
*/
`timescale 1ns/10ps
`include "watchdog_consts.svh"

module watchdog_timer_prescaled
   import watchdog_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic [13:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   input  wire logic [7:0]  configuration_word_i,
   input  wire logic        clear_watchdog_cmd_i,
   input  wire logic        sleep_cmd_i,
   input  wire logic        crystal_clock_i,
   input  wire logic        ost_start_i,
   input  wire logic        clock_fail_i,
   output logic      [7:0]  rdata_o,
   output logic             watchdog_reset_o,
   output logic             wake_o,
   output logic             timeout_flag_o,
   output logic      [1:0]  system_clock_select_o,
   output logic             ost_busy_o,
   output logic             irq_o
);

   // ======================================================================
   // Registers
   logic [7:0]  option_control;
   logic [7:0]  watchdog_control;
   logic [1:0]  irq_status;
   logic [1:0]  irq_mask;
   wd_state_t   state;
   logic [12:0] rc_div;
   logic        rc_tick;
   logic [15:0] prescaler;
   logic [6:0]  postscaler;
   logic [10:0] ost_count;
   logic        wd_tick;
   logic        post_tick;
   logic        running;
   logic        scaler_clear;
   logic        timeout;
   logic [3:0]  period_select;
   logic [15:0] pre_mask;
   logic [6:0]  post_mask;
   logic        wr_ctrl;
   logic        rd_status;

   assign period_select = watchdog_control[4:1];
   assign wr_ctrl = wr_i && (addr_i == `OFS_WATCHDOG_CONTROL);
   assign rd_status = rd_i && (addr_i == `OFS_IRQ_STATUS);

   // Enable: force-on overrides the software bit.
   assign running = (configuration_word_i[`CFG_FORCE_ON_BIT]
                    || watchdog_control[`BIT_SW_ENABLE])
                    && (state != ST_OST);

   // Scaler clear sources; sleep entry clears at once, a start-up clears at its end.
   assign scaler_clear = clear_watchdog_cmd_i
                         || clock_fail_i
                         || (sleep_cmd_i && state == ST_RUN)
                         || (state == ST_OST && ost_count == 11'h000);

   // ======================================================================
   // Internal RC tick: a one-cycle enable at 31.25 kHz.
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rc_div  <= 13'h0000;
         rc_tick <= 1'b0;
      end
      else if (rc_div == 13'(`INTERNAL_RC_OSC_DIV - 1))
      begin
         rc_div  <= 13'h0000;
         rc_tick <= 1'b1;
      end
      else
      begin
         rc_div  <= rc_div + 13'h0001;
         rc_tick <= 1'b0;
      end
   end

   // ======================================================================
   // Prescaler; code 1100 bypasses it for a 1:1 rate.
   always_comb
   begin
      if (period_select == `PERIOD_SEL_ONE)
         pre_mask = 16'h0000;
      else if (period_select > 4'hB)
         pre_mask = 16'hFFFF;
      else
         pre_mask = 16'((32'h20 << period_select) - 32'h1);
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         prescaler <= 16'h0000;
      else if (scaler_clear || !running)
         prescaler <= 16'h0000;
      else if (rc_tick)
         prescaler <= ((prescaler & pre_mask) == pre_mask) ? 16'h0000
                      : prescaler + 16'h0001;
   end

   assign wd_tick = running && rc_tick && ((prescaler & pre_mask) == pre_mask);

   // ======================================================================
   // Postscaler, shared with the option scale select when assigned.
   // Seven bits give 1:128 at most, so 2.097 s x 128 reaches about 268 s.
   assign post_mask = option_control[`BIT_PRESCALER_ASSIGN]
                      ? 7'((8'h01 << option_control[2:0]) - 8'h01)
                      : 7'h00;

   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         postscaler <= 7'h00;
      else if (scaler_clear || !running)
         postscaler <= 7'h00;
      else if (wd_tick)
         postscaler <= ((postscaler & post_mask) == post_mask) ? 7'h00
                       : postscaler + 7'h01;
   end

   assign post_tick = wd_tick && ((postscaler & post_mask) == post_mask);
   assign timeout = post_tick && !scaler_clear;

   // ======================================================================
   // Sleep and oscillator start-up sequencing.
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state     <= ST_RUN;
         ost_count <= 11'h000;
      end
      else
      begin
         case (state)
            ST_RUN:
            begin
               if (ost_start_i)
               begin
                  state     <= ST_OST;
                  ost_count <= 11'(`OST_CYCLES);
               end
               else if (sleep_cmd_i)
                  state <= ST_SLEEP;
            end
            ST_SLEEP:
            begin
               if (timeout)
               begin
                  state     <= crystal_clock_i ? ST_OST : ST_RUN;
                  ost_count <= 11'(`OST_CYCLES);
               end
            end
            ST_OST:
            begin
               if (ost_count == 11'h000)
                  state <= ST_RUN;
               else if (rc_tick)
                  ost_count <= ost_count - 11'h001;
            end
            default:
               state <= ST_RUN;
         endcase
      end
   end

   // ======================================================================
   // Outputs of the watchdog itself.
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         watchdog_reset_o <= 1'b0;
         wake_o           <= 1'b0;
         timeout_flag_o   <= 1'b1;
         ost_busy_o       <= 1'b0;
      end
      else
      begin
         watchdog_reset_o <= timeout && (state != ST_SLEEP);
         wake_o           <= timeout && (state == ST_SLEEP);
         ost_busy_o       <= (state == ST_OST);
         if (timeout)
            timeout_flag_o <= 1'b0;
         else if (sleep_cmd_i && state == ST_RUN)
            timeout_flag_o <= 1'b1;
         else if (clear_watchdog_cmd_i)
            timeout_flag_o <= 1'b1;
      end
   end

   // Clock failure forces the internal RC select; a sleep command returns it to 0 otherwise.
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         system_clock_select_o <= 2'h0;
      else if (clock_fail_i)
         system_clock_select_o <= 2'h2;
      else if (sleep_cmd_i)
         system_clock_select_o <= 2'h0;
   end

   // ======================================================================
   // Register writes.
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         watchdog_control <= `RST_WATCHDOG_CONTROL;
         option_control   <= `RST_OPTION_CONTROL;
         irq_mask         <= 2'h0;
      end
      else
      begin
         if (wr_ctrl)
            watchdog_control <= {3'h0, wdata_i[4:0]};
         if (wr_i && (addr_i == `OFS_OPTION_CONTROL || addr_i == `OFS_OPTION_ALIAS))
            option_control <= wdata_i;
         if (wr_i && addr_i == `OFS_IRQ_MASK)
            irq_mask <= wdata_i[1:0];
      end
   end

   // Sticky events: bit 0 time-out, bit 1 wake. A new event wins over the read clear.
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         irq_status <= 2'h0;
      else
         irq_status <= (rd_status ? 2'h0 : irq_status)
                       | {timeout && state == ST_SLEEP, timeout};
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(irq_status & irq_mask);
   end

   // ======================================================================
   // Register reads; unmapped addresses read zero.
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         rdata_o <= 8'h00;
      else if (rd_i)
      begin
         case (addr_i)
            `OFS_OPTION_CONTROL,
            `OFS_OPTION_ALIAS:     rdata_o <= option_control;
            `OFS_WATCHDOG_CONTROL: rdata_o <= {3'h0, watchdog_control[4:0]};
            `OFS_CONFIG_WORD:      rdata_o <= configuration_word_i;
            `OFS_IRQ_STATUS:       rdata_o <= {6'h00, irq_status};
            `OFS_IRQ_MASK:         rdata_o <= {6'h00, irq_mask};
            `OFS_WD_STATUS:        rdata_o <= {4'h0, timeout_flag_o, running,
                                               state == ST_OST, state == ST_SLEEP};
            default:               rdata_o <= 8'h00;
         endcase
      end
      else
         rdata_o <= 8'h00;
   end

endmodule : watchdog_timer_prescaled

// [watchdog_timer_prescaled_checker.sv]
/*
 Assertions on the ports of the prescaled watchdog.
 Assumes one clock domain and a bind from the testbench top file.
*/
`timescale 1ns/10ps
module watchdog_timer_prescaled_checker (
   input wire logic        core_clk_i,
   input wire logic        rst_b_i,
   input wire logic [13:0] addr_i,
   input wire logic [7:0]  wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [7:0]  configuration_word_i,
   input wire logic        clear_watchdog_cmd_i,
   input wire logic        sleep_cmd_i,
   input wire logic        crystal_clock_i,
   input wire logic        ost_start_i,
   input wire logic        clock_fail_i,
   input wire logic [7:0]  rdata_o,
   input wire logic        watchdog_reset_o,
   input wire logic        wake_o,
   input wire logic        timeout_flag_o,
   input wire logic [1:0]  system_clock_select_o,
   input wire logic        ost_busy_o,
   input wire logic        irq_o
);
   // ======================================================================
   // Properties
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   a_ctrl_upper_zero: assert property (rd_i && addr_i == 14'h0105 |=> rdata_o[7:5] == 3'h0)
      else $error("control upper bits not zero");
   a_read_idle_zero: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   a_reset_pulse_gap: assert property (watchdog_reset_o |=> !watchdog_reset_o [*8])
      else $error("time-out pulses too close");
   a_wake_pulse_gap: assert property (wake_o |=> !wake_o [*8])
      else $error("wake pulses too close");
   a_timeout_flag_low: assert property ((watchdog_reset_o || wake_o) && !clear_watchdog_cmd_i
      && !sleep_cmd_i |=> !timeout_flag_o)
      else $error("time-out flag not cleared");
   a_clear_sets_flag: assert property (sleep_cmd_i || clear_watchdog_cmd_i |=> timeout_flag_o)
      else $error("time-out flag not set by clear");
   a_clear_no_timeout: assert property (clear_watchdog_cmd_i |=> !watchdog_reset_o)
      else $error("time-out right after clear");
   a_fail_clock_select: assert property (clock_fail_i |=> system_clock_select_o == 2'h2)
      else $error("clock select not forced on failure");
   a_ost_start_busy: assert property (ost_start_i |-> ##2 ost_busy_o)
      else $error("start-up timer not busy");
   a_ost_holds_dog: assert property (ost_busy_o && $past(ost_busy_o) |-> !watchdog_reset_o && !wake_o)
      else $error("time-out during start-up");
endmodule : watchdog_timer_prescaled_checker
